// File: core/tppc_pkg.sv
// Shared constants and types of the three-phase pre-driver control block.
package tppc_pkg;

  // ****************************************
  // Serial frame
  // ****************************************
  localparam int FRAME_BITS = 8;
  localparam logic [7:0] CLEAR_INT_OPCODE = 8'h80;
  localparam logic [7:0] MASK_LOW_OPCODE = 8'h40;
  localparam logic [7:0] MASK_HIGH_OPCODE = 8'h50;
  localparam logic [7:0] MODE_OPCODE = 8'h30;
  localparam logic [7:0] STATUS_OPCODE = 8'h10;
  localparam logic [3:0] OP_FIELD_MASK = 4'hf;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;
  localparam logic [3:0] MASK_ALL_NONE = 4'h0;
  localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_ONE = 3'h1;

  // ****************************************
  // Mode bits
  // ****************************************
  localparam int MODE_OVERRIDE_BIT = 0;
  localparam int MODE_BITS = 4;

  // ****************************************
  // Deadtime
  // ****************************************
  localparam int DEAD_NS = 200;
  localparam int CLK_NS = 40;
  localparam int DEAD_CYCLES = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DEAD_LOAD = 4'(DEAD_CYCLES);
  localparam logic [3:0] DEAD_ZERO = 4'h0;
  localparam logic [3:0] DEAD_ONE = 4'h1;

  // ****************************************
  // Phase driver states
  // ****************************************
  typedef enum logic [1:0] {
    TPPC_OFF,
    TPPC_LOW,
    TPPC_HIGH,
    TPPC_DEAD
  } tppc_phase_state_t;

endpackage

// File: core/tppc_phase.sv
// One phase of gate drive with bootstrap gating, plus crossover deadtime and blocking outside override mode.
`timescale 1ns/1ps
`default_nettype none
module tppc_phase (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Commands, already synchronised
  input wire logic high_req,
  input wire logic low_req,
  input wire logic gate_ok,
  input wire logic override,
  // Gate drives
  output logic high_side_driver,
  output logic low_side_driver
);
  import tppc_pkg::*;

  typedef struct packed {
    tppc_phase_state_t state;
    logic [3:0] dead;
    logic boot_ok;
    logic high;
    logic low;
  } tppc_ph_t;

  tppc_ph_t cur;
  tppc_ph_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.high = 1'b0;
    next_cur.low = 1'b0;
    if (!gate_ok) begin
      // Losing an enable drops both gates and asks for a new bootstrap charge.
      next_cur.state = TPPC_OFF;
      next_cur.boot_ok = 1'b0;
      next_cur.dead = DEAD_ZERO;
    end else if (override) begin
      next_cur.state = TPPC_OFF;
      next_cur.high = high_req && cur.boot_ok;
      next_cur.low = low_req;
      if (low_req) begin
        next_cur.boot_ok = 1'b1;
      end
    end else begin
      case (cur.state)
        TPPC_OFF: begin
          if (low_req && !high_req) begin
            next_cur.state = TPPC_LOW;
            next_cur.low = 1'b1;
            next_cur.boot_ok = 1'b1;
          end else if (high_req && !low_req && cur.boot_ok) begin
            next_cur.state = TPPC_HIGH;
            next_cur.high = 1'b1;
          end
        end
        TPPC_LOW: begin
          if (low_req && !high_req) begin
            next_cur.low = 1'b1;
          end else begin
            next_cur.state = TPPC_DEAD;
            next_cur.dead = DEAD_LOAD;
          end
        end
        TPPC_HIGH: begin
          if (high_req && !low_req) begin
            next_cur.high = 1'b1;
          end else begin
            next_cur.state = TPPC_DEAD;
            next_cur.dead = DEAD_LOAD;
          end
        end
        TPPC_DEAD: begin
          if (cur.dead <= DEAD_ONE) begin
            next_cur.state = TPPC_OFF;
            next_cur.dead = DEAD_ZERO;
          end else begin
            next_cur.dead = cur.dead - DEAD_ONE;
          end
        end
        default: begin
          next_cur.state = TPPC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Gates fall as soon as the synchronised enables drop, ahead of the state update.
  assign high_side_driver = cur.high && gate_ok;
  assign low_side_driver = cur.low && gate_ok;

endmodule
`default_nettype wire

// File: core/tppc_top.sv
// Control logic of a three-phase gate pre-driver: serial port, faults, gate drive.
`timescale 1ns/1ps
`default_nettype none
module tppc_top (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic supply_good,
  // Enables and gate commands from the controller
  input wire logic gate_enable_first,
  input wire logic gate_enable_second,
  input wire logic high_cmd_a_n,
  input wire logic high_cmd_b_n,
  input wire logic high_cmd_c_n,
  input wire logic low_cmd_a,
  input wire logic low_cmd_b,
  input wire logic low_cmd_c,
  // Serial port, link clock domain
  input wire logic ser_clk,
  input wire logic chip_sel_n,
  input wire logic ser_in,
  output logic ser_out,
  output logic ser_out_oe_n,
  // Analog comparator results
  input wire logic phase_above_a,
  input wire logic phase_above_b,
  input wire logic phase_above_c,
  input wire logic overcurrent_det,
  input wire logic [7:0] fault_src,
  // Outputs to the controller
  output logic compare_out_a,
  output logic compare_out_b,
  output logic compare_out_c,
  output logic overcurrent_flag_out,
  output logic int_out,
  // Gate drives
  output logic [2:0] high_side_driver,
  output logic [2:0] low_side_driver,
  output logic driver_float
);
  import tppc_pkg::*;

  // ****************************************
  // Reset combination
  // ****************************************
  // Reset pin and power-on detector clear everything asynchronously.
  logic core_rst;
  assign core_rst = rst || !reset_n || !supply_good;

  // ****************************************
  // Serial shifter on the link clock
  // ****************************************
  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
    logic done_tgl;
    logic [7:0] word;
  } tppc_rx_t;

  tppc_rx_t rx;
  tppc_rx_t next_rx;
  logic ser_rst;
  assign ser_rst = core_rst || chip_sel_n;

  always_comb begin
    next_rx = rx;
    next_rx.shift = {rx.shift[6:0], ser_in};
    next_rx.cnt = rx.cnt + BIT_CNT_ONE;
    if (rx.cnt == BIT_CNT_LAST) begin
      next_rx.word = {rx.shift[6:0], ser_in};
      next_rx.done_tgl = !rx.done_tgl;
    end
  end

  // Word-complete toggle must survive chip select so it lives in its own flop.
  logic done_tgl_keep;
  always_ff @(negedge ser_clk or posedge core_rst) begin
    if (core_rst) begin
      done_tgl_keep <= 1'b0;
    end else if (!chip_sel_n && rx.cnt == BIT_CNT_LAST) begin
      done_tgl_keep <= !done_tgl_keep;
    end
  end

  logic [7:0] rx_word;
  always_ff @(negedge ser_clk or posedge core_rst) begin
    if (core_rst) begin
      rx_word <= 8'h00;
    end else if (!chip_sel_n && rx.cnt == BIT_CNT_LAST) begin
      rx_word <= next_rx.word;
    end
  end

  always_ff @(negedge ser_clk or posedge ser_rst) begin
    if (ser_rst) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // Status is shifted out on rising edges from a snapshot frozen in the system domain.
  // The snapshot stops following the status two system cycles after chip select falls,
  // well before the first rising serial edge, so the word is steady when it is loaded.
  logic [7:0] tx_shift;
  logic [7:0] status_word;
  logic [7:0] tx_snap;
  logic tx_first;
  always_ff @(posedge ser_clk or posedge ser_rst) begin
    if (ser_rst) begin
      tx_shift <= 8'h00;
      tx_first <= 1'b1;
    end else begin
      tx_first <= 1'b0;
      if (tx_first) begin
        tx_shift <= tx_snap;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end
  assign ser_out = tx_shift[7];
  assign ser_out_oe_n = chip_sel_n || core_rst;

  // ****************************************
  // Crossing into the system clock
  // ****************************************
  typedef struct packed {
    logic [2:0] tgl_sync;
    logic [7:0] cmd;
    logic cmd_stb;
    logic [3:0] mask_low;
    logic [3:0] mask_high;
    logic [3:0] mode;
    logic [7:0] pend;
    logic irq;
    logic [1:0] en_a_sync;
    logic [1:0] en_b_sync;
    logic [2:0] hi_s1;
    logic [2:0] hi_s2;
    logic [2:0] lo_s1;
    logic [2:0] lo_s2;
    logic [2:0] ph_s1;
    logic [2:0] ph_s2;
    logic [1:0] oc_sync;
    logic [1:0] cs_sync;
    logic [7:0] snap;
  } tppc_sys_t;

  tppc_sys_t st;
  tppc_sys_t next_st;
  logic [7:0] fault_sync1;
  logic [7:0] fault_sync2;

  always_ff @(posedge sys_clk or posedge core_rst) begin
    if (core_rst) begin
      fault_sync1 <= 8'h00;
      fault_sync2 <= 8'h00;
    end else begin
      fault_sync1 <= fault_src;
      fault_sync2 <= fault_sync1;
    end
  end

  function automatic logic [3:0] op_of(input logic [7:0] w);
    op_of = w[7:4];
  endfunction

  logic [7:0] live_mask;
  logic [7:0] set_pend;
  assign live_mask = {st.mask_high, st.mask_low};
  assign set_pend = fault_sync2 & ~live_mask;

  always_comb begin
    next_st = st;
    next_st.tgl_sync = {st.tgl_sync[1:0], done_tgl_keep};
    next_st.cmd_stb = st.tgl_sync[2] ^ st.tgl_sync[1];
    if (st.tgl_sync[2] ^ st.tgl_sync[1]) begin
      next_st.cmd = rx_word;
    end
    next_st.pend = st.pend | set_pend;
    if (st.cmd_stb) begin
      case (op_of(st.cmd))
        op_of(CLEAR_INT_OPCODE): begin
          // New faults in the same cycle stay pending.
          next_st.pend = set_pend;
        end
        op_of(MASK_LOW_OPCODE): next_st.mask_low = st.cmd[3:0];
        op_of(MASK_HIGH_OPCODE): next_st.mask_high = st.cmd[3:0];
        op_of(MODE_OPCODE): next_st.mode = st.cmd[3:0];
        default: begin
          next_st.mode = st.mode;
        end
      endcase
    end
    next_st.irq = |next_st.pend;
    next_st.en_a_sync = {st.en_a_sync[0], gate_enable_first};
    next_st.en_b_sync = {st.en_b_sync[0], gate_enable_second};
    next_st.hi_s1 = ~{high_cmd_c_n, high_cmd_b_n, high_cmd_a_n};
    next_st.hi_s2 = st.hi_s1;
    next_st.lo_s1 = {low_cmd_c, low_cmd_b, low_cmd_a};
    next_st.lo_s2 = st.lo_s1;
    next_st.ph_s1 = {phase_above_c, phase_above_b, phase_above_a};
    next_st.ph_s2 = st.ph_s1;
    next_st.oc_sync = {st.oc_sync[0], overcurrent_det};
    next_st.cs_sync = {st.cs_sync[0], chip_sel_n};
    if (st.cs_sync[1]) begin
      next_st.snap = status_word;
    end
  end

  always_ff @(posedge sys_clk or posedge core_rst) begin
    if (core_rst) begin
      st <= '0;
      st.mask_low <= MASK_ALL_NONE;
      st.mask_high <= MASK_ALL_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign status_word = {st.pend[7:4], st.oc_sync[1], st.ph_s2};
  assign tx_snap = st.snap;

  // ****************************************
  // Outputs to the controller
  // ****************************************
  assign compare_out_a = st.ph_s2[0];
  assign compare_out_b = st.ph_s2[1];
  assign compare_out_c = st.ph_s2[2];
  assign overcurrent_flag_out = st.oc_sync[1];
  assign int_out = st.irq;
  assign driver_float = !supply_good;

  // ****************************************
  // Gate drive
  // ****************************************
  // The state machines see only the synchronised enables; the raw pins merely mask
  // the drives, so an enable drop needs no clock and only the synchroniser flops sample a raw pin.
  logic gate_ok;
  logic raw_enables;
  wire logic [2:0] phase_high;
  wire logic [2:0] phase_low;
  assign raw_enables = gate_enable_first && gate_enable_second;
  assign gate_ok = st.en_a_sync[1] && st.en_b_sync[1];

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      tppc_phase u_phase (
        .sys_clk(sys_clk),
        .rst(core_rst),
        .high_req(st.hi_s2[ph]),
        .low_req(st.lo_s2[ph]),
        .gate_ok(gate_ok),
        .override(st.mode[MODE_OVERRIDE_BIT]),
        .high_side_driver(phase_high[ph]),
        .low_side_driver(phase_low[ph])
      );
    end
  endgenerate

  assign high_side_driver = raw_enables ? phase_high : 3'h0;
  assign low_side_driver = raw_enables ? phase_low : 3'h0;

endmodule
`default_nettype wire

// File: test/tppc_assertions.sv
// Port-level checks of the pre-driver control block.
`timescale 1ns/1ps
`default_nettype none
module tppc_assertions (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic supply_good,
  // Inputs watched
  input wire logic gate_enable_first,
  input wire logic gate_enable_second,
  input wire logic high_cmd_a_n,
  input wire logic low_cmd_a,
  input wire logic chip_sel_n,
  input wire logic phase_above_a,
  input wire logic overcurrent_det,
  // Outputs watched
  input wire logic ser_out_oe_n,
  input wire logic compare_out_a,
  input wire logic overcurrent_flag_out,
  input wire logic int_out,
  input wire logic [2:0] high_side_driver,
  input wire logic [2:0] low_side_driver,
  input wire logic driver_float
);
  logic [3:0] since_cs;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !reset_n || !supply_good);
  // Counts cycles since the last frame, so a dropped interrupt can be tied to a command.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_cs <= 4'hf;
    end else if (!chip_sel_n) begin
      since_cs <= 4'h0;
    end else if (since_cs != 4'hf) begin
      since_cs <= since_cs + 4'h1;
    end
  end
  a_gate_off:
    assert property (!(gate_enable_first && gate_enable_second) |-> high_side_driver == 3'h0
      && low_side_driver == 3'h0) else $error("gate drive on while disabled");
  a_reset_quiet:
    assert property (disable iff (rst) !reset_n |-> !int_out && high_side_driver == 3'h0
      && ser_out_oe_n) else $error("outputs active in reset");
  a_float_low:
    assert property (disable iff (rst) !supply_good |-> driver_float && ser_out_oe_n)
      else $error("drivers not floated at low supply");
  a_int_clear:
    assert property ($fell(int_out) |-> since_cs < 4'ha)
      else $error("interrupt dropped without a command");
  a_oe_idle:
    assert property (chip_sel_n [*4] |-> ser_out_oe_n)
      else $error("serial out driven while deselected");
  a_high_cause:
    assert property ($rose(high_side_driver[0]) |-> !$past(high_cmd_a_n, 3))
      else $error("high side on without low command level");
  a_low_cause:
    assert property ($rose(low_side_driver[0]) |-> $past(low_cmd_a, 3))
      else $error("low side on without high command level");
  a_cmp_follow:
    assert property ($stable(phase_above_a) [*4] |-> compare_out_a == phase_above_a)
      else $error("comparator output stale");
  a_oc_follow:
    assert property ($stable(overcurrent_det) [*4] |-> overcurrent_flag_out == overcurrent_det)
      else $error("overcurrent flag stale");
  c_int_up: cover property ($rose(int_out));
  c_int_down: cover property ($fell(int_out));
  c_high_on: cover property ($rose(high_side_driver[0]));
endmodule
`default_nettype wire

// File: test/tppc_host_model.sv
// Controller model that frames serial commands to the block.
`timescale 1ns/1ps
`default_nettype none
module tppc_host_model (
  // Serial lines to the block
  output logic ser_clk,
  output logic chip_sel_n,
  output logic ser_in,
  // Serial lines from the block
  input wire logic ser_out,
  input wire logic ser_out_oe_n
);
  initial begin
    ser_clk = 1'b0;
    chip_sel_n = 1'b1;
    ser_in = 1'b0;
  end
  // Sends one byte at a 64 ns serial period; sel low clocks with the port deselected.
  task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    chip_sel_n = !sel;
    #100;
    for (int i = 7; i >= 0; i--) begin
      ser_clk = 1'b1;
      ser_in = tx[i];
      #32;
      ser_clk = 1'b0;
      rx[i] = ser_out_oe_n ? 1'bx : ser_out;
      #32;
    end
    #68;
    chip_sel_n = 1'b1;
    ser_in = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the pre-driver control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tppc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1, reset_n = 1'b1, supply_good = 1'b1;
  logic gate_enable_first = 1'b0, gate_enable_second = 1'b0;
  logic high_cmd_a_n = 1'b1, high_cmd_b_n = 1'b1, high_cmd_c_n = 1'b1;
  logic low_cmd_a = 1'b0, low_cmd_b = 1'b0, low_cmd_c = 1'b0;
  logic phase_above_a = 1'b0, phase_above_b = 1'b0, phase_above_c = 1'b0;
  logic overcurrent_det = 1'b0;
  logic [7:0] fault_src = 8'h00;
  wire logic ser_clk, chip_sel_n, ser_in;
  logic ser_out, ser_out_oe_n, compare_out_a, compare_out_b, compare_out_c;
  logic overcurrent_flag_out, int_out, driver_float;
  logic [2:0] high_side_driver, low_side_driver;
  logic [7:0] rx;
  wire logic [7:0] outs, sense;
  int error_cnt = 0, compares = 0, cycles = 0;
  assign outs = {high_side_driver, low_side_driver, int_out, driver_float};
  assign sense = {3'h0, ser_out_oe_n, overcurrent_flag_out, compare_out_c, compare_out_b, compare_out_a};
  tppc_top uut (.sys_clk, .rst, .reset_n, .supply_good, .gate_enable_first, .gate_enable_second,
    .high_cmd_a_n, .high_cmd_b_n, .high_cmd_c_n, .low_cmd_a, .low_cmd_b, .low_cmd_c,
    .ser_clk, .chip_sel_n, .ser_in, .ser_out, .ser_out_oe_n, .phase_above_a, .phase_above_b,
    .phase_above_c, .overcurrent_det, .fault_src, .compare_out_a, .compare_out_b, .compare_out_c,
    .overcurrent_flag_out, .int_out, .high_side_driver, .low_side_driver, .driver_float);
  tppc_host_model host (.ser_clk, .chip_sel_n, .ser_in, .ser_out, .ser_out_oe_n);
  // ******
  // Shared tasks
  // ******
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_gate;
    chk(outs, 8'h00);
    chk(sense, 8'h10);
    @(posedge sys_clk);
    gate_enable_first <= 1'b1;
    gate_enable_second <= 1'b1;
    low_cmd_a <= 1'b1;
    cyc(3);
    chk(outs, 8'h04);
    @(posedge sys_clk);
    low_cmd_a <= 1'b0;
    high_cmd_a_n <= 1'b0;
    high_cmd_b_n <= 1'b0;
    cyc(12);
    chk(outs, 8'h20);
    @(posedge sys_clk);
    gate_enable_second <= 1'b0;
    #1;
    chk(outs, 8'h00);
    @(posedge sys_clk);
    gate_enable_second <= 1'b1;
    cyc(10);
    chk(outs, 8'h00);
    @(posedge sys_clk);
    high_cmd_a_n <= 1'b1;
    high_cmd_b_n <= 1'b1;
  endtask
  task automatic t_override;
    @(posedge sys_clk);
    low_cmd_c <= 1'b1;
    cyc(4);
    @(posedge sys_clk);
    high_cmd_c_n <= 1'b0;
    cyc(12);
    chk(outs, 8'h00);
    host.xfer(MODE_OPCODE | 8'h01, 1'b1, rx);
    cyc(16);
    chk(outs, 8'h90);
    host.xfer(MODE_OPCODE, 1'b1, rx);
    @(posedge sys_clk);
    low_cmd_c <= 1'b0;
    high_cmd_c_n <= 1'b1;
    cyc(12);
  endtask
  task automatic t_status;
    @(posedge sys_clk);
    phase_above_a <= 1'b1;
    phase_above_c <= 1'b1;
    overcurrent_det <= 1'b1;
    cyc(4);
    chk(sense, 8'h1d);
    host.xfer(STATUS_OPCODE, 1'b1, rx);
    chk(rx, 8'h0d);
    @(posedge sys_clk);
    phase_above_a <= 1'b0;
    phase_above_b <= 1'b1;
    phase_above_c <= 1'b0;
    overcurrent_det <= 1'b0;
    cyc(4);
    chk(sense, 8'h12);
    @(posedge sys_clk);
    phase_above_b <= 1'b0;
    cyc(4);
    chk(sense, 8'h10);
  endtask
  task automatic t_fault;
    host.xfer(MASK_HIGH_OPCODE | 8'h02, 1'b1, rx);
    host.xfer(MASK_LOW_OPCODE | 8'h01, 1'b1, rx);
    @(posedge sys_clk);
    fault_src <= 8'h21;
    @(posedge sys_clk);
    fault_src <= 8'h00;
    cyc(6);
    chk(outs, 8'h00);
    host.xfer(CLEAR_INT_OPCODE, 1'b1, rx);
    host.xfer(MASK_LOW_OPCODE, 1'b1, rx);
    host.xfer(MASK_HIGH_OPCODE, 1'b1, rx);
    @(posedge sys_clk);
    fault_src <= 8'h02;
    @(posedge sys_clk);
    fault_src <= 8'h00;
    cyc(24);
    chk(outs, 8'h02);
    host.xfer(CLEAR_INT_OPCODE, 1'b0, rx);
    cyc(6);
    chk(outs, 8'h02);
    host.xfer(CLEAR_INT_OPCODE, 1'b1, rx);
    cyc(6);
    chk(outs, 8'h00);
  endtask
  task automatic t_power;
    @(posedge sys_clk);
    fault_src <= 8'h04;
    low_cmd_a <= 1'b1;
    cyc(6);
    chk(outs, 8'h06);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    #77;
    chk(outs, 8'h00);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    supply_good <= 1'b0;
    fault_src <= 8'h00;
    cyc(2);
    chk(outs, 8'h01);
    chk(sense, 8'h10);
    @(posedge sys_clk);
    supply_good <= 1'b1;
    low_cmd_a <= 1'b0;
    cyc(4);
  endtask
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    t_gate;
    t_override;
    t_status;
    t_fault;
    t_power;
    final_report;
  end
endmodule
bind tppc_top tppc_assertions chk (.sys_clk, .rst, .reset_n, .supply_good, .gate_enable_first,
  .gate_enable_second, .high_cmd_a_n, .low_cmd_a, .chip_sel_n, .phase_above_a, .overcurrent_det,
  .ser_out_oe_n, .compare_out_a, .overcurrent_flag_out, .int_out, .high_side_driver,
  .low_side_driver, .driver_float);
`default_nettype wire
